//--- src/lowlat_pkg.sv
// constants and types shared by both ends of the local request port
// assumes a single 200 MHz system clock for both ends
package lowlat_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // power-up settle time before reads and writes are allowed
  localparam int INIT_TIME_NS  = 1000;
  localparam int INIT_CYCLES   = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // row cycle time kept by the user end between requests
  localparam int TRC_NS        = 30;
  localparam int TRC_CYCLES    = (TRC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BANK_W        = 3;
  localparam int DLY_W         = 6;
  localparam int DLY_TAPS      = 64;
  localparam int FIFO_DEPTH    = 16;
  localparam int GANG_W        = 4;
  localparam int SYNC_STAGES   = 2;
  localparam logic CMD_IDLE    = 1'h1;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_REFRESH
  } op_t;
endpackage : lowlat_pkg

//--- src/lowlat_link.sv
// link between the user end and the controller end of the local port
// assumes both ends share clk and rst_b
`timescale 1ns/100ps
`default_nettype none
interface lowlat_link #(
  parameter int ADDR_W  = 20,
  parameter int NUM_DEV = 2,
  parameter int DQ_W    = 9
) (
  input wire logic clk,
  input wire logic rst_b
);
  logic [ADDR_W-1:0]               addr;
  logic [lowlat_pkg::BANK_W-1:0]   bank;
  logic [2*NUM_DEV-1:0]            user_byte_mask;
  logic [2*NUM_DEV*DQ_W-1:0]       wdata;
  logic                            read_req;
  logic                            write_req;
  logic                            refresh_req;
  logic                            init_done;
  logic                            cmd_ready;
  logic [NUM_DEV*DQ_W-1:0]         rdata;
  logic [NUM_DEV-1:0]              rdata_valid;
  logic                            rdata_ready;

  modport dev (
    input  clk, rst_b, addr, bank, user_byte_mask, wdata, read_req, write_req, refresh_req,
    input  rdata_ready,
    output init_done, cmd_ready, rdata, rdata_valid
  );
  modport usr (
    input  clk, rst_b, init_done, cmd_ready, rdata, rdata_valid,
    output addr, bank, user_byte_mask, wdata, read_req, write_req, refresh_req, rdata_ready
  );
endinterface : lowlat_link
`default_nettype wire

//--- src/lowlat_fifo.sv
// flop based fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/100ps
`default_nettype none
module lowlat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push != pop) begin
        cnt_q <= push ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
    end
  end
endmodule : lowlat_fifo
`default_nettype wire

//--- src/lowlat_dev_end.sv
// controller end of the local request port: command issue and read capture
// assumes memory pins, strobes and foreign resets are asynchronous to clk
//
// How it works
// RULE1 - command clock equals system clock frequency
// RULE2 - system reset low, released on clock edge
// RULE3 - command reset low, released on its edge
// RULE4 - read resets: per device, or one
// RULE5 - read reset low, released on capture edge
// RULE6 - undelayed capture strobe out per device
// RULE7 - six-bit delay control shifts read strobes
// RULE8 - non-strobe mode uses external capture clock
// RULE9 - address width is a build parameter
// RULE10 - three-bit bank address per request
// RULE11 - two mask bits per device; all-high suppresses
// RULE12 - refresh request refreshes the given bank
// RULE13 - no self-generated refreshes
// RULE14 - read issued at once, no queue
// RULE15 - held refresh gives one per cycle
// RULE16 - user spaces refreshes for row cycle
// RULE17 - no read/write before init done
// RULE18 - any reset held keeps commands idle
`timescale 1ns/100ps
`default_nettype none
module lowlat_dev_end #(
  parameter int ADDR_W   = 20,
  parameter int NUM_DEV  = 2,
  parameter int DQ_W     = 9,
  parameter bit DQS_MODE = 1'b1,
  parameter int NRST     = DQS_MODE ? NUM_DEV : 1
) (
  // local side
  lowlat_link.dev                          lnk,
  // resets of the other domains
  input  wire logic                        cmd_rst_n,
  input  wire logic [NRST-1:0]             rd_rst_n,
  // read capture
  input  wire logic [lowlat_pkg::DLY_W-1:0] dly_ctrl,
  input  wire logic [NUM_DEV-1:0]          mem_strobe,
  input  wire logic                        ext_cap_clk,
  output logic [NUM_DEV-1:0]               capture_clk,
  // memory side
  output logic                             mem_cs_n,
  output logic                             mem_we_n,
  output logic                             mem_ref_n,
  output logic [ADDR_W-1:0]                mem_a,
  output logic [lowlat_pkg::BANK_W-1:0]    mem_ba,
  output logic [NUM_DEV-1:0]               mem_byte_mask,
  output logic [NUM_DEV*DQ_W-1:0]          mem_d,
  input  wire logic [NUM_DEV*DQ_W-1:0]     mem_q,
  input  wire logic [NUM_DEV-1:0]          mem_qvld
);
  localparam int DW = NUM_DEV * DQ_W;
  localparam int SW = 1 + NRST + NUM_DEV + 1 + NUM_DEV + DW + lowlat_pkg::DLY_W;

  logic                   clk;
  logic                   rst_b;
  logic [SW-1:0]          sync1_q;
  logic [SW-1:0]          sync2_q;
  logic                   cmd_rst_s;
  logic [NRST-1:0]        rrst_s;
  logic [NUM_DEV-1:0]     strobe_s;
  logic                   ext_s;
  logic [NUM_DEV-1:0]     qvld_s;
  logic [DW-1:0]          q_s;
  logic [lowlat_pkg::DLY_W-1:0] dly_s;
  logic                   all_rst_ok;
  logic [lowlat_pkg::DLY_TAPS-1:0] dline_q [NUM_DEV];
  logic [NUM_DEV-1:0]     dly_prev_q;
  logic                   ext_prev_q;
  logic [NUM_DEV-1:0]     edge_hit;
  logic [NUM_DEV-1:0]     cap_vld_q;
  logic [DW-1:0]          cap_data_q;
  logic [15:0]            init_cnt_q;
  logic                   init_done_q;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [NUM_DEV+DW-1:0]  fifo_out_data;
  logic                   issue_rd;
  logic                   issue_wr;
  logic                   beat_q;
  logic [DW-1:0]          wd_hi_q;
  logic [NUM_DEV-1:0]     mask_hi_q;

  // one mask bit per device for the given beat
  function automatic logic [NUM_DEV-1:0] mask_beat(input logic [2*NUM_DEV-1:0] m,
                                                   input logic                 hi);
    logic [NUM_DEV-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_DEV; i++) begin
      r[i] = m[2*i + (hi ? 1 : 0)];
    end
    return r;
  endfunction : mask_beat

  assign clk   = lnk.clk;
  assign rst_b = lnk.rst_b; // [RULE2]

  // two-stage synchroniser for every foreign input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {cmd_rst_n, rd_rst_n, mem_strobe, ext_cap_clk, mem_qvld, mem_q, dly_ctrl};
      sync2_q <= sync1_q;
    end
  end

  assign {cmd_rst_s, rrst_s, strobe_s, ext_s, qvld_s, q_s, dly_s} = sync2_q;
  assign all_rst_ok = cmd_rst_s & (&rrst_s); // [RULE3] [RULE5]

  // strobe delay line, tap picked by the delay control bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_DEV; i++) begin
        dline_q[i] <= '0;
      end
      dly_prev_q  <= '0;
      ext_prev_q  <= 1'b0;
      capture_clk <= '0;
    end else begin
      for (int i = 0; i < NUM_DEV; i++) begin
        dline_q[i]    <= {dline_q[i][lowlat_pkg::DLY_TAPS-2:0], strobe_s[i]};
        dly_prev_q[i] <= dline_q[i][dly_s]; // [RULE7]
      end
      ext_prev_q  <= ext_s;
      capture_clk <= DQS_MODE ? strobe_s : '0; // [RULE6]
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_DEV; i++) begin
      if (DQS_MODE) begin
        edge_hit[i] = dline_q[i][dly_s] & ~dly_prev_q[i] & rrst_s[DQS_MODE ? i : 0]; // [RULE4]
      end else begin
        edge_hit[i] = ext_s & ~ext_prev_q & rrst_s[0]; // [RULE8] [RULE4]
      end
    end
  end

  // capture read data on the chosen edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_vld_q  <= '0;
      cap_data_q <= '0;
    end else begin
      for (int i = 0; i < NUM_DEV; i++) begin
        cap_vld_q[i] <= edge_hit[i] & qvld_s[i];
        if (edge_hit[i] & qvld_s[i]) begin
          cap_data_q[i*DQ_W +: DQ_W] <= q_s[i*DQ_W +: DQ_W];
        end
      end
    end
  end

  lowlat_fifo #(
    .WIDTH (NUM_DEV + DW),
    .DEPTH (lowlat_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (|cap_vld_q),
    .in_ready  (fifo_in_ready),
    .in_data   ({cap_vld_q, cap_data_q}),
    .out_valid (fifo_out_valid),
    .out_ready (lnk.rdata_ready),
    .out_data  (fifo_out_data)
  );

  assign lnk.rdata       = fifo_out_data[DW-1:0];
  assign lnk.rdata_valid = fifo_out_valid ? fifo_out_data[NUM_DEV+DW-1:DW] : '0;

  // settle count once all resets are released
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt_q  <= '0;
      init_done_q <= 1'b0;
    end else if (!all_rst_ok) begin
      init_cnt_q  <= '0;
      init_done_q <= 1'b0;
    end else if (init_cnt_q == 16'(lowlat_pkg::INIT_CYCLES - 1)) begin
      init_done_q <= 1'b1;
    end else begin
      init_cnt_q <= init_cnt_q + 16'h0001;
    end
  end

  assign lnk.init_done = init_done_q;
  assign lnk.cmd_ready = init_done_q & fifo_in_ready & all_rst_ok; // [RULE17]
  assign issue_rd = ~lnk.refresh_req & lnk.read_req & lnk.cmd_ready;
  assign issue_wr = ~lnk.refresh_req & ~lnk.read_req & lnk.write_req & lnk.cmd_ready;

  // command issue, one command per cycle, refresh first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_cs_n  <= lowlat_pkg::CMD_IDLE;
      mem_we_n  <= lowlat_pkg::CMD_IDLE;
      mem_ref_n <= lowlat_pkg::CMD_IDLE;
      mem_a     <= '0;
      mem_ba    <= '0;
    end else if (!all_rst_ok) begin
      mem_cs_n  <= lowlat_pkg::CMD_IDLE; // [RULE18]
      mem_we_n  <= lowlat_pkg::CMD_IDLE; // [RULE18]
      mem_ref_n <= lowlat_pkg::CMD_IDLE; // [RULE18]
    end else begin
      mem_cs_n  <= ~(lnk.refresh_req | issue_rd | issue_wr);
      mem_we_n  <= ~issue_wr;
      mem_ref_n <= ~lnk.refresh_req; // [RULE12] [RULE13] [RULE15]
      if (lnk.refresh_req | issue_rd | issue_wr) begin
        mem_ba <= lnk.bank; // [RULE10] [RULE12]
      end
      if (issue_rd | issue_wr) begin
        mem_a <= lnk.addr; // [RULE9] [RULE14]
      end
    end
  end

  // write data and mask, low beat with the command, high beat after
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      beat_q        <= 1'b0;
      wd_hi_q       <= '0;
      mask_hi_q     <= '0;
      mem_d         <= '0;
      mem_byte_mask <= '0;
    end else if (issue_wr & all_rst_ok) begin
      beat_q        <= 1'b1;
      mem_d         <= lnk.wdata[DW-1:0];
      wd_hi_q       <= lnk.wdata[2*DW-1:DW];
      mem_byte_mask <= mask_beat(lnk.user_byte_mask, 1'b0); // [RULE11]
      mask_hi_q     <= mask_beat(lnk.user_byte_mask, 1'b1); // [RULE11]
    end else if (beat_q) begin
      beat_q        <= 1'b0;
      mem_d         <= wd_hi_q;
      mem_byte_mask <= mask_hi_q;
    end else begin
      mem_byte_mask <= '0;
    end
  end
endmodule : lowlat_dev_end
`default_nettype wire

//--- src/lowlat_usr_end.sv
// user end of the local request port: paces operations onto the link
// assumes the controller end shares clk; one operation accepted at a time
`timescale 1ns/100ps
`default_nettype none
module lowlat_usr_end #(
  parameter int ADDR_W  = 20,
  parameter int NUM_DEV = 2,
  parameter int DQ_W    = 9,
  parameter int TRC     = lowlat_pkg::TRC_CYCLES
) (
  // link to the controller
  lowlat_link.usr                              lnk,
  // operation request
  input  wire logic                            op_valid,
  input  wire lowlat_pkg::op_t                 op_kind,
  input  wire logic [ADDR_W-1:0]               op_addr,
  input  wire logic [lowlat_pkg::BANK_W-1:0]   op_bank,
  input  wire logic [2*NUM_DEV-1:0]            op_mask,
  input  wire logic [2*NUM_DEV*DQ_W-1:0]       op_wdata,
  input  wire logic [lowlat_pkg::GANG_W-1:0]   op_refs,
  output logic                                 op_ready,
  // read data return
  output logic [NUM_DEV*DQ_W-1:0]              rd_data,
  output logic [NUM_DEV-1:0]                   rd_hit,
  output logic                                 rd_valid,
  input  wire logic                            rd_ready,
  // status
  output logic                                 init_done
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GANG,
    ST_GAP
  } usr_state_t;

  usr_state_t                     state_q;
  logic [lowlat_pkg::GANG_W-1:0]  left_q;
  logic [7:0]                     gap_q;
  logic [lowlat_pkg::BANK_W-1:0]  bank_q;
  logic                           take;
  logic                           is_ref;

  assign is_ref   = (op_kind == lowlat_pkg::OP_REFRESH);
  assign op_ready = (state_q == ST_IDLE) & (is_ref | lnk.cmd_ready); // [RULE17]
  assign take     = op_valid & op_ready;

  assign lnk.read_req       = take & (op_kind == lowlat_pkg::OP_READ);
  assign lnk.write_req      = take & (op_kind == lowlat_pkg::OP_WRITE);
  assign lnk.refresh_req    = (take & is_ref) | (state_q == ST_GANG); // [RULE15]
  assign lnk.bank           = (state_q == ST_GANG) ? bank_q : op_bank;
  assign lnk.addr           = op_addr;
  assign lnk.user_byte_mask = op_mask;
  assign lnk.wdata          = op_wdata;
  assign lnk.rdata_ready    = rd_ready;
  assign rd_data            = lnk.rdata;
  assign rd_hit             = lnk.rdata_valid;
  assign rd_valid           = |lnk.rdata_valid;
  assign init_done          = lnk.init_done;

  // ganged refresh then row cycle gap
  always_ff @(posedge lnk.clk or negedge lnk.rst_b) begin
    if (!lnk.rst_b) begin
      state_q <= ST_IDLE;
      left_q  <= '0;
      gap_q   <= '0;
      bank_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            bank_q <= op_bank;
            gap_q  <= 8'(TRC - 1);
            if (is_ref && op_refs > 1) begin
              left_q  <= op_refs - 2'd2;
              state_q <= ST_GANG;
            end else if (TRC > 1) begin
              state_q <= ST_GAP; // [RULE16]
            end
          end
        end
        ST_GANG: begin
          if (left_q == '0) begin
            state_q <= (TRC > 1) ? ST_GAP : ST_IDLE;
          end else begin
            left_q <= left_q - 1'b1;
          end
        end
        ST_GAP: begin
          if (gap_q <= 8'h01) begin
            state_q <= ST_IDLE;
          end else begin
            gap_q <= gap_q - 8'h01; // [RULE16]
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : lowlat_usr_end
`default_nettype wire

//--- testbench/lowlat_link_asserts.sv
// checker for the local request link between user end and controller end
// assumes one clock, link reset async active low, user end TRC of 6
`timescale 1ns/100ps
`default_nettype none
module lowlat_link_asserts #(
  parameter int NUM_DEV = 2,
  parameter int DQ_W    = 9
) (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           rst_b,
  // requests
  input wire logic [lowlat_pkg::BANK_W-1:0]  bank,
  input wire logic                           read_req,
  input wire logic                           write_req,
  input wire logic                           refresh_req,
  // status and read return
  input wire logic                           init_done,
  input wire logic                           cmd_ready,
  input wire logic [NUM_DEV*DQ_W-1:0]        rdata,
  input wire logic [NUM_DEV-1:0]             rdata_valid,
  input wire logic                           rdata_ready
);
  logic [15:0] cyc_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // cycles since reset release or since init was lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q <= 16'h0;
    end else if ($fell(init_done)) begin
      cyc_q <= 16'h0;
    end else if (cyc_q != 16'hFFFF) begin
      cyc_q <= cyc_q + 16'h1;
    end
  end

  property p_rd_init;
    read_req |-> init_done && cmd_ready;
  endproperty
  a_rd_init: assert property (p_rd_init) else $error("early read");
  property p_wr_init;
    write_req |-> init_done && cmd_ready;
  endproperty
  a_wr_init: assert property (p_wr_init) else $error("early write");
  property p_one_req;
    $onehot0({read_req, write_req, refresh_req});
  endproperty
  a_one_req: assert property (p_one_req) else $error("two requests");
  property p_spacing;
    (read_req || write_req) |=> !(read_req || write_req || refresh_req) [*5];
  endproperty
  a_spacing: assert property (p_spacing) else $error("row cycle broken");
  property p_gang_bank;
    refresh_req ##1 refresh_req |-> $stable(bank);
  endproperty
  a_gang_bank: assert property (p_gang_bank) else $error("gang bank moved");
  property p_init_time;
    $rose(init_done) |-> cyc_q >= lowlat_pkg::INIT_CYCLES;
  endproperty
  a_init_time: assert property (p_init_time) else $error("init too soon");
  property p_rdata_hold;
    (rdata_valid != '0) && !rdata_ready |=> $stable(rdata) && $stable(rdata_valid);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read word lost");
  property p_reset_idle;
    $rose(rst_b) |-> !init_done && !read_req && !write_req && (rdata_valid == '0);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("busy at reset");

  c_write: cover property (write_req);
  c_gang: cover property (refresh_req [*2]);
  c_stall: cover property ((rdata_valid != '0) && !rdata_ready);
endmodule : lowlat_link_asserts
`default_nettype wire

//--- testbench/lowlat_dram_ctrl_clk_rst_local_port_tb.sv
// bench: user end and controller end joined by the link, memory pins driven here
// assumes the src/ files compile first; DQS mode, 2 devices
`timescale 1ns/100ps
`default_nettype none
module lowlat_dram_ctrl_clk_rst_local_port_tb;
  localparam int AW = 20;
  localparam int ND = 2;
  localparam int DW = 18;
  logic                  clk;
  logic                  rst_b;
  logic                  cmd_rst_n;
  logic [ND-1:0]         rd_rst_n;
  logic [5:0]            dly_ctrl;
  logic [ND-1:0]         mem_strobe;
  logic [ND-1:0]         mem_qvld;
  logic [ND-1:0]         capture_clk;
  logic                  mem_cs_n;
  logic                  mem_we_n;
  logic                  mem_ref_n;
  logic [AW-1:0]         mem_a;
  logic [2:0]            mem_ba;
  logic [ND-1:0]         mem_byte_mask;
  logic [DW-1:0]         mem_d;
  logic [DW-1:0]         mem_q;
  logic                  op_valid;
  lowlat_pkg::op_t       op_kind;
  logic [AW-1:0]         op_addr;
  logic [2:0]            op_bank;
  logic [2*ND-1:0]       op_mask;
  logic [2*DW-1:0]       op_wdata;
  logic [3:0]            op_refs;
  logic                  op_ready;
  logic [DW-1:0]         rd_data;
  logic [ND-1:0]         rd_hit;
  logic                  rd_valid;
  logic                  rd_ready;
  logic                  init_done;
  logic [63:0]           rnd;
  logic [DW-1:0]         exp_q[$];
  int                    bad_count = 0;
  int                    compares = 0;
  int                    cs_cnt = 0;
  int                    n;
  int                    lat0;
  int                    lat1;

  lowlat_link i_lowlat_link (.clk(clk), .rst_b(rst_b));
  lowlat_dev_end i_lowlat_dev_end (.lnk(i_lowlat_link), .cmd_rst_n(cmd_rst_n),
    .rd_rst_n(rd_rst_n), .dly_ctrl(dly_ctrl), .mem_strobe(mem_strobe), .ext_cap_clk(1'h0),
    .capture_clk(capture_clk), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
    .mem_ref_n(mem_ref_n), .mem_a(mem_a), .mem_ba(mem_ba), .mem_byte_mask(mem_byte_mask),
    .mem_d(mem_d), .mem_q(mem_q), .mem_qvld(mem_qvld));
  lowlat_usr_end i_lowlat_usr_end (.lnk(i_lowlat_link), .op_valid(op_valid),
    .op_kind(op_kind), .op_addr(op_addr), .op_bank(op_bank), .op_mask(op_mask),
    .op_wdata(op_wdata), .op_refs(op_refs), .op_ready(op_ready), .rd_data(rd_data),
    .rd_hit(rd_hit), .rd_valid(rd_valid), .rd_ready(rd_ready), .init_done(init_done));
  lowlat_link_asserts i_lowlat_link_asserts (.clk(clk), .rst_b(rst_b),
    .bank(i_lowlat_link.bank), .read_req(i_lowlat_link.read_req),
    .write_req(i_lowlat_link.write_req), .refresh_req(i_lowlat_link.refresh_req),
    .init_done(i_lowlat_link.init_done), .cmd_ready(i_lowlat_link.cmd_ready),
    .rdata(i_lowlat_link.rdata), .rdata_valid(i_lowlat_link.rdata_valid),
    .rdata_ready(i_lowlat_link.rdata_ready));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem_cs_n === 1'h0) cs_cnt++;
  end

  task automatic test_done();
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int exp);
    chk_val(64'(got), 64'(exp));
  endtask : chk_cnt

  // mask bits of one write beat
  function automatic logic [ND-1:0] beat_mask(input logic [2*ND-1:0] m, input int beat);
    for (int i = 0; i < ND; i++) beat_mask[i] = m[2*i+beat];
  endfunction : beat_mask

  // data bits of the devices that hit
  function automatic logic [DW-1:0] dev_bits(input logic [ND-1:0] hit);
    for (int i = 0; i < ND; i++) dev_bits[i*(DW/ND) +: DW/ND] = {(DW/ND){hit[i]}};
  endfunction : dev_bits

  task automatic wait_init();
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (init_done !== 1'h1 && i < 1000);
    if (init_done !== 1'h1) begin
      bad_count++;
      test_done();
    end
  endtask : wait_init

  // offer one operation and return at its take edge
  task automatic do_op(input lowlat_pkg::op_t k, input logic [63:0] v, input logic [3:0] r);
    int i;
    @(posedge clk);
    op_valid <= 1'h1;
    op_kind  <= k;
    op_wdata <= v[2*DW-1:0];
    op_addr  <= v[AW+35:36];
    op_bank  <= v[58:56];
    op_mask  <= v[62:59];
    op_refs  <= r;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (op_ready !== 1'h1 && i < 200);
    if (op_ready !== 1'h1) begin
      bad_count++;
      test_done();
    end
    @(posedge clk);
    op_valid <= 1'h0;
  endtask : do_op

  task automatic run_op(input lowlat_pkg::op_t k, input logic [63:0] v, input logic [3:0] r);
    do_op(k, v, r);
    if (k == lowlat_pkg::OP_REFRESH) begin
      n = 0;
      repeat (8) begin
        @(negedge clk);
        if (mem_ref_n === 1'h0) begin
          n++;
          chk_val(mem_ba, v[58:56]);
          chk_val(mem_cs_n, 1'h0);
        end
      end
      chk_cnt(n, (r == 4'h0) ? 1 : int'(r));
    end else begin
      @(negedge clk);
      chk_val({mem_cs_n, mem_we_n, mem_ref_n}, {2'h0, k == lowlat_pkg::OP_READ, 1'h1});
      chk_val(mem_a, v[AW+35:36]);
      chk_val(mem_ba, v[58:56]);
      if (k == lowlat_pkg::OP_WRITE) begin
        chk_val(mem_d, v[DW-1:0]);
        chk_val(mem_byte_mask, beat_mask(v[62:59], 0));
        @(negedge clk);
        chk_val(mem_cs_n, 1'h1);
        chk_val(mem_d, v[2*DW-1:DW]);
        chk_val(mem_byte_mask, beat_mask(v[62:59], 1));
      end
    end
  endtask : run_op

  // strobe devices s with data q; wait for the read word when wt is set
  task automatic pulse(input logic [ND-1:0] s, input logic [ND-1:0] hit,
                       input logic [DW-1:0] q, input bit wt, output int lat);
    @(posedge clk);
    mem_strobe <= s;
    mem_qvld   <= s;
    mem_q      <= q;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (wt ? (rd_valid !== 1'h1 && lat < 100) : lat < 4);
    if (wt && rd_valid !== 1'h1) begin
      bad_count++;
      test_done();
    end
    if (wt) begin
      chk_val(rd_data & dev_bits(hit), q & dev_bits(hit));
      chk_val(rd_hit, hit);
    end else begin
      chk_val(capture_clk, s);
    end
    @(posedge clk);
    mem_strobe <= '0;
    mem_qvld   <= '0;
    mem_q      <= ~q;
    repeat (4) @(posedge clk);
  endtask : pulse

  initial begin
    {rst_b, cmd_rst_n, rd_rst_n, dly_ctrl, mem_strobe, mem_qvld, mem_q} = '0;
    {op_valid, op_addr, op_bank, op_mask, op_wdata, op_refs} = '0;
    op_kind  = lowlat_pkg::OP_READ;
    rd_ready = 1'h1;
    void'($urandom(99));
    repeat (10) @(posedge clk);
    rst_b     <= 1'h1;
    cmd_rst_n <= 1'h1;
    rd_rst_n  <= '1;
    wait_init();
    run_op(lowlat_pkg::OP_WRITE, {1'h0, 4'hF, 3'h7, 20'hFFFFF, 36'h9_A5A5_5A5A}, 4'h0);
    run_op(lowlat_pkg::OP_READ, 64'h0, 4'h0);
    run_op(lowlat_pkg::OP_REFRESH, {$urandom(), $urandom()}, 4'h0);
    run_op(lowlat_pkg::OP_REFRESH, {$urandom(), $urandom()}, 4'h1);
    run_op(lowlat_pkg::OP_REFRESH, {$urandom(), $urandom()}, 4'h4);
    repeat (24) begin
      rnd = {$urandom(), $urandom()};
      run_op(lowlat_pkg::op_t'(rnd[63]), rnd, 4'h0);
    end
    n = cs_cnt;
    repeat (100) @(posedge clk);
    chk_cnt(cs_cnt, n);
    @(posedge clk);
    cmd_rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    n = cs_cnt;
    do_op(lowlat_pkg::OP_REFRESH, 64'h0, 4'h2);
    repeat (8) @(negedge clk);
    chk_cnt(cs_cnt, n);
    chk_val(init_done, 1'h0);
    @(posedge clk);
    cmd_rst_n <= 1'h1;
    wait_init();
    pulse(2'h3, 2'h3, 18'h2_C3A5, 1'h1, lat0);
    dly_ctrl <= 6'h5;
    pulse(2'h3, 2'h3, 18'h1_3C5A, 1'h1, lat1);
    chk_cnt(lat1 - lat0, 5);
    dly_ctrl <= 6'h0;
    rd_rst_n <= 2'h1;
    repeat (4) @(posedge clk);
    pulse(2'h3, 2'h1, 18'h0_F00F, 1'h1, lat0);
    rd_rst_n <= 2'h3;
    wait_init();
    @(posedge clk);
    rd_ready <= 1'h0;
    for (int i = 0; i < 18; i++) begin
      rnd = {$urandom(), $urandom()};
      if (i < 16) exp_q.push_back(rnd[DW-1:0]);
      pulse(2'h3, 2'h3, rnd[DW-1:0], 1'h0, lat0);
    end
    @(negedge clk);
    chk_val(i_lowlat_link.cmd_ready, 1'h0);
    @(posedge clk);
    rd_ready <= 1'h1;
    foreach (exp_q[i]) begin
      @(negedge clk);
      chk_val({rd_valid, rd_data}, {1'h1, exp_q[i]});
    end
    @(negedge clk);
    chk_val(rd_valid, 1'h0);
    test_done();
  end
endmodule : lowlat_dram_ctrl_clk_rst_local_port_tb
`default_nettype wire
